// File: core/tws_defines.svh
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
// power-up delay in microseconds and clock rate in MHz
`define TWS_PWRUP_US 100
`define TWS_CLK_MHZ 20
`define TWS_PWRUP_CYC (`TWS_PWRUP_US * `TWS_CLK_MHZ)
// scl half period in core clocks (400 ns scl period at 20 MHz)
`define TWS_HALF_CYC 4
`define TWS_BITS_PER_BYTE 4'h8
`define TWS_RECOVER_CLKS 4'h9
`define TWS_FIFO_DEPTH 8
`define TWS_FIFO_AW 3
`endif

// File: core/tws_pkg.sv
package tws_pkg;
	typedef enum logic [1:0] {
		TWS_CMD_START,
		TWS_CMD_WRITE,
		TWS_CMD_READ,
		TWS_CMD_STOP
	} tws_cmd_e;

	typedef enum logic [3:0] {
		TWS_ST_PWRUP,
		TWS_ST_IDLE,
		TWS_ST_STA_A,
		TWS_ST_STA_B,
		TWS_ST_BIT_LO,
		TWS_ST_BIT_HI,
		TWS_ST_ACK_LO,
		TWS_ST_ACK_HI,
		TWS_ST_STO_A,
		TWS_ST_STO_B,
		TWS_ST_STO_C,
		TWS_ST_REC_LO,
		TWS_ST_REC_HI
	} tws_state_e;
endpackage

// File: core/tws_fifo.sv
`timescale 1ns/1ns
`include "tws_defines.svh"
// small synchronous fifo with valid/ready on both sides
module tws_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = `TWS_FIFO_DEPTH,
	parameter int AW = `TWS_FIFO_AW
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// honest full and empty from the occupancy count
	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage has no reset, only pointers and count do
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	// pointers and occupancy
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule // tws_fifo

// File: core/tws_master.sv
// Overview of operation
// - wait power_up_delay after reset release before first command
// - sample sda on rising scl (this core samples at the end of scl high); change sda only while scl is low
// - shift every byte most significant bit first, one bit per clock
// - each byte is nine scl cycles: eight data bits then acknowledge
// - clock each byte and its acknowledge without pauses
// - sda changes only while scl low, stable during scl high
// - every command sequence opens with a start condition
// - a repeated start may replace stop before the next operation
// - bus idle only when scl and sda are both high
// - transmitter releases sda after the eighth bit falling edge
// - acknowledge is sda held low through the ninth clock high phase
// - master reading ends with nack, leaving sda high on ninth clock
// - receiver releases sda at the end of the ninth clock
// - recovery: clock scl up to nine times until sda high, then start (this core returns to idle and leaves the start to the user)
`timescale 1ns/1ns
`include "tws_defines.svh"
module tws_master #(
	parameter int PWRUP_CYC = `TWS_PWRUP_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] cmd,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_last,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic recover,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic ack_seen,
	output logic nack_seen,
	output logic bus_idle,
	output logic busy,
	output logic scl_o,
	output logic scl_oe,
	input wire logic scl_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic sda_i
);
	// fifo entry: {cmd, last, data}
	logic [10:0] f_out;
	logic f_valid;
	logic f_pop;
	logic f_in_ready;
	tws_pkg::tws_state_e st_r;
	logic [$clog2(PWRUP_CYC+1)-1:0] pwr_cnt_r;
	logic [2:0] half_cnt_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] sh_r;
	logic is_read_r;
	logic last_r;
	logic frame_r;
	logic scl_s1_r;
	logic scl_s2_r;
	logic sda_s1_r;
	logic sda_s2_r;
	logic sda_prev_r;
	logic tick;

	// buffered command queue, back-pressure reaches the caller
	tws_fifo #(.WIDTH(11), .DEPTH(`TWS_FIFO_DEPTH), .AW(`TWS_FIFO_AW)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_data({cmd, cmd_last, cmd_data}),
		.in_valid(cmd_valid),
		.in_ready(f_in_ready),
		.out_data(f_out),
		.out_valid(f_valid),
		.out_ready(f_pop)
	);

	function automatic logic half_done(input logic [2:0] c);
		half_done = (c == 3'(`TWS_HALF_CYC - 1));
	endfunction

	assign tick = half_done(half_cnt_r);
	assign f_pop = (st_r == tws_pkg::TWS_ST_IDLE) && f_valid && !recover;
	assign cmd_ready = f_in_ready;

	// two-flop synchronisers on the pins; first stage read only by the second
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_prev_r <= 1'b1;
		end
		else
		begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_prev_r <= sda_s2_r;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			bus_idle <= 1'b0;
		else
			bus_idle <= scl_s2_r && sda_s2_r && sda_prev_r;
	end

	// half-period timer, restarts on every state change
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			half_cnt_r <= '0;
		else if (st_r == tws_pkg::TWS_ST_IDLE || st_r == tws_pkg::TWS_ST_PWRUP || tick)
			half_cnt_r <= '0;
		else
			half_cnt_r <= half_cnt_r + 3'h1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pwr_cnt_r <= '0;
		else if (st_r == tws_pkg::TWS_ST_PWRUP)
			pwr_cnt_r <= pwr_cnt_r + 1'b1;
	end

	// scl is push-pull from this end; sda open drain, o tied low
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_oe <= 1'b0;
			scl_o <= 1'b1;
			sda_o <= 1'b0;
		end
		else
		begin
			scl_oe <= 1'b1;
			sda_o <= 1'b0;
			// scl low in low phases, parked low between bytes so no stray clock escapes
			scl_o <= !(st_r == tws_pkg::TWS_ST_BIT_LO || st_r == tws_pkg::TWS_ST_ACK_LO
				|| st_r == tws_pkg::TWS_ST_STO_A || st_r == tws_pkg::TWS_ST_REC_LO
				|| st_r == tws_pkg::TWS_ST_IDLE && frame_r || st_r == tws_pkg::TWS_ST_STA_A && sda_oe
				|| st_r == tws_pkg::TWS_ST_STA_B && tick);
		end
	end

	// main sequencer
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= tws_pkg::TWS_ST_PWRUP;
			sda_oe <= 1'b0;
			bit_cnt_r <= '0;
			sh_r <= '0;
			is_read_r <= 1'b0;
			last_r <= 1'b0;
			frame_r <= 1'b0;
			rd_data <= '0;
			rd_valid <= 1'b0;
			ack_seen <= 1'b0;
			nack_seen <= 1'b0;
			busy <= 1'b1;
		end
		else
		begin
			rd_valid <= 1'b0;
			ack_seen <= 1'b0;
			nack_seen <= 1'b0;
			unique case (st_r)
				// nothing issued while the device may be in reset
				tws_pkg::TWS_ST_PWRUP:
				begin
					if (pwr_cnt_r >= ($bits(pwr_cnt_r))'(PWRUP_CYC - 1))
					begin
						st_r <= tws_pkg::TWS_ST_IDLE;
						busy <= 1'b0;
					end
				end
				tws_pkg::TWS_ST_IDLE:
				begin
					// let go of sda once scl is already low; a recover request lets go at once
					if (!scl_o)
						sda_oe <= 1'b0;
					if (recover)
					begin
						sda_oe <= 1'b0;
						bit_cnt_r <= '0;
						busy <= 1'b1;
						st_r <= tws_pkg::TWS_ST_REC_LO;
					end
					else if (f_valid)
					begin
						busy <= 1'b1;
						sh_r <= f_out[7:0];
						last_r <= f_out[8];
						bit_cnt_r <= '0;
						unique case (tws_pkg::tws_cmd_e'(f_out[10:9]))
							// start, also used as repeated start
							tws_pkg::TWS_CMD_START: st_r <= tws_pkg::TWS_ST_STA_A;
							tws_pkg::TWS_CMD_WRITE:
							begin
								is_read_r <= 1'b0;
								st_r <= tws_pkg::TWS_ST_BIT_LO;
							end
							tws_pkg::TWS_CMD_READ:
							begin
								is_read_r <= 1'b1;
								st_r <= tws_pkg::TWS_ST_BIT_LO;
							end
							tws_pkg::TWS_CMD_STOP: st_r <= tws_pkg::TWS_ST_STO_A;
						endcase
					end
				end
				// start: sda released with scl high, then pull sda low
				tws_pkg::TWS_ST_STA_A:
				begin
					sda_oe <= 1'b0;
					if (tick)
						st_r <= tws_pkg::TWS_ST_STA_B;
				end
				tws_pkg::TWS_ST_STA_B:
				begin
					sda_oe <= 1'b1;
					if (tick)
					begin
						frame_r <= 1'b1;
						st_r <= tws_pkg::TWS_ST_IDLE;
						busy <= 1'b0;
					end
				end
				tws_pkg::TWS_ST_BIT_LO:
				begin
					// drive data during scl low; msb first
					if (!scl_o)
						sda_oe <= is_read_r ? 1'b0 : !sh_r[7];
					if (tick)
						st_r <= tws_pkg::TWS_ST_BIT_HI;
				end
				tws_pkg::TWS_ST_BIT_HI:
				begin
					if (tick)
					begin
						// sample at end of scl high phase
						sh_r <= {sh_r[6:0], sda_s2_r};
						bit_cnt_r <= bit_cnt_r + 4'h1;
						// eight bits then the ack cycle, no gaps
						st_r <= (bit_cnt_r == `TWS_BITS_PER_BYTE - 4'h1)
							? tws_pkg::TWS_ST_ACK_LO : tws_pkg::TWS_ST_BIT_LO;
					end
				end
				tws_pkg::TWS_ST_ACK_LO:
				begin
					// release after eighth bit; nack on last read
					if (!scl_o)
						sda_oe <= is_read_r && !last_r;
					if (tick)
						st_r <= tws_pkg::TWS_ST_ACK_HI;
				end
				tws_pkg::TWS_ST_ACK_HI:
				begin
					if (tick)
					begin
						// ack is low through the ninth high phase
						if (is_read_r)
						begin
							rd_data <= sh_r;
							rd_valid <= 1'b1;
						end
						else
						begin
							ack_seen <= !sda_s2_r;
							nack_seen <= sda_s2_r;
						end
						st_r <= tws_pkg::TWS_ST_IDLE;
						busy <= 1'b0;
					end
				end
				// stop: scl low with sda low, scl high, then release sda
				tws_pkg::TWS_ST_STO_A:
				begin
					// hold sda low only after the ninth clock ended
					sda_oe <= 1'b1;
					if (tick)
						st_r <= tws_pkg::TWS_ST_STO_B;
				end
				tws_pkg::TWS_ST_STO_B:
				begin
					if (tick)
						st_r <= tws_pkg::TWS_ST_STO_C;
				end
				tws_pkg::TWS_ST_STO_C:
				begin
					sda_oe <= 1'b0;
					frame_r <= 1'b0;
					if (tick)
					begin
						st_r <= tws_pkg::TWS_ST_IDLE;
						busy <= 1'b0;
					end
				end
				tws_pkg::TWS_ST_REC_LO:
				begin
					if (tick)
						st_r <= tws_pkg::TWS_ST_REC_HI;
				end
				tws_pkg::TWS_ST_REC_HI:
				begin
					if (tick)
					begin
						bit_cnt_r <= bit_cnt_r + 4'h1;
						// stop once sda high or nine clocks used; user then starts
						if (sda_s2_r || bit_cnt_r == `TWS_RECOVER_CLKS - 4'h1)
						begin
							st_r <= tws_pkg::TWS_ST_IDLE;
							busy <= 1'b0;
						end
						else
							st_r <= tws_pkg::TWS_ST_REC_LO;
					end
				end
				default:
					st_r <= tws_pkg::TWS_ST_IDLE;
			endcase
		end
	end
endmodule // tws_master

// File: testbench/tws_chk_sva.sv
`timescale 1ns/1ns
// pin watch; scl rises are counted only inside a frame
module tws_chk_sva #(
	parameter int PWRUP_CYC = 2000
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic busy,
	input wire logic bus_idle,
	input wire logic ack_seen,
	input wire logic nack_seen,
	input wire logic rd_valid,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic scl_i,
	input wire logic sda_i
);
	logic scl_q;
	logic oe_q;
	logic inb;
	logic [3:0] rises;
	int pw;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// sda moving under a high scl marks start or stop
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			inb <= 1'b0;
			rises <= 4'h0;
		end
		else
		begin
			scl_q <= scl_o;
			oe_q <= sda_oe;
			if (scl_o && scl_q && sda_oe != oe_q)
			begin
				inb <= sda_oe;
				rises <= 4'h0;
			end
			else if (inb && scl_o && !scl_q)
				rises <= (rises == 4'h8) ? 4'h0 : rises + 4'h1;
		end
	end
	// cycles since reset release, saturating
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			pw <= 0;
		else if (pw < PWRUP_CYC)
			pw <= pw + 1;
	end
	quiet_reset_a: assert property (disable iff (1'b0) rst |-> !sda_oe && !scl_oe && busy)
		else $error("bus driven in reset");
	pwrup_wait_a: assert property (pw < PWRUP_CYC - 2 |-> busy && !sda_oe)
		else $error("bus used too early");
	rise_steady_a: assert property ($rose(scl_o) |-> $stable(sda_oe))
		else $error("sda moved at scl rise");
	high_steady_a: assert property (
		scl_o && $past(scl_o) && rises inside {[2:8]} |-> $stable(sda_oe))
		else $error("sda moved while scl high");
	frame_nine_a: assert property (
		ack_seen || nack_seen || rd_valid |-> inb && rises == 4'h0)
		else $error("byte not nine clocks");
	high_len_a: assert property (
		$rose(scl_o) && rises inside {[1:7]} |-> scl_o [*4] ##1 !scl_o)
		else $error("scl high phase length");
	low_len_a: assert property (
		$fell(scl_o) && rises inside {[1:8]} |-> !scl_o [*4] ##1 scl_o)
		else $error("scl low phase length");
	idle_seen_a: assert property ((scl_i && sda_i) [*8] |-> bus_idle)
		else $error("idle bus not flagged");
	cover property (ack_seen);
	cover property (nack_seen);
	cover property (rd_valid);
endmodule // tws_chk_sva

// File: testbench/tws_dev_model.sv
`timescale 1ns/1ns
// behavioural eeprom front end on the far side
module tws_dev_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic tx,
	input wire logic [7:0] tx_byte,
	input wire logic nak,
	input wire logic jam,
	output logic pull,
	output logic [7:0] rx_byte,
	output logic mack
);
	int cnt = 0;
	int jc = 0;
	logic act = 1'b0;
	// modelled as always out of reset, ideal edge-clean pins
	initial
	begin
		pull = 1'b0;
		rx_byte = 8'h00;
		mack = 1'b0;
	end
	// falling sda under high scl opens
	always @(negedge sda)
	begin
		if (scl)
		begin
			act = 1'b1;
			cnt = 0;
			mack = 1'b0;
		end
	end
	// rising sda under high scl closes
	always @(posedge sda)
	begin
		if (scl)
			act = 1'b0;
	end
	always @(posedge scl)
	begin
		if (act && cnt < 8)
			rx_byte = {rx_byte[6:0], sda};
		else if (act)
			mack = sda;
		cnt++;
	end
	// stuck low until the fifth scl fall, to exercise recovery
	always @(posedge jam)
	begin
		jc = 5;
		pull = 1'b1;
	end
	// drive after fall, pull low only
	always @(negedge scl)
	begin
		if (jc > 0)
			jc--;
		if (cnt == 9)
			cnt = 0;
		if (jc > 0 || !act)
			pull = jc > 0;
		else if (tx)
			pull = !mack && cnt < 8 && !tx_byte[7 - cnt];
		else
			pull = cnt == 8 && !nak;
	end
endmodule // tws_dev_model

// File: testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic core_clk = 1'b0;
	logic rst;
	logic [1:0] cmd = 2'h0;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_last = 1'b0;
	logic cmd_valid = 1'b0;
	logic recover = 1'b0;
	logic tx = 1'b0;
	logic nak = 1'b0;
	logic jam = 1'b0;
	logic [7:0] tx_byte = 8'h00;
	logic [7:0] rd_data;
	logic [7:0] m_rx;
	logic cmd_ready, rd_valid, ack_seen, nack_seen, bus_idle, busy;
	logic scl_o, scl_oe, sda_o, sda_oe, pull, mack;
	int fails = 0;
	int comparisons = 0;
	int rises = 0;
	// pull-ups on both lines, sda wired-and
	wire scl = scl_oe ? scl_o : 1'b1;
	wire sda = (sda_oe ? sda_o : 1'b1) && !pull;
	tws_master #(.PWRUP_CYC(20)) dut (.core_clk, .rst, .cmd, .cmd_data, .cmd_last,
		.cmd_valid, .cmd_ready, .recover, .rd_data, .rd_valid, .ack_seen, .nack_seen,
		.bus_idle, .busy, .scl_o, .scl_oe, .scl_i(scl), .sda_o, .sda_oe, .sda_i(sda));
	tws_dev_model eep (.scl, .sda, .tx, .tx_byte, .nak, .jam, .pull, .rx_byte(m_rx), .mack);
	initial
	begin
		forever #25 core_clk = ~core_clk;
	end
	// bus clock rises, for the recovery count
	always @(posedge scl)
		rises++;
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tmo;
		fails++;
		summarize();
	endtask
	// ready is combinational, so judge it at the falling edge
	task automatic push(input logic [1:0] c, input logic [7:0] d, input logic l);
		int n;
		@(negedge core_clk);
		cmd = c;
		cmd_data = d;
		cmd_last = l;
		cmd_valid = 1'b1;
		for (n = 0; n < 400 && !cmd_ready; n++)
			@(negedge core_clk);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		if (n == 400)
			tmo();
	endtask
	// next result pulse; always skips the current cycle
	task automatic ev;
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		while (!(ack_seen || nack_seen || rd_valid) && n < 300);
		if (n == 300)
			tmo();
	endtask
	task automatic idle;
		int n;
		for (n = 0; n < 10 && !busy; n++)
			@(negedge core_clk);
		for (n = 0; n < 400 && busy !== 1'b0; n++)
			@(negedge core_clk);
		if (n == 400)
			tmo();
		for (n = 0; n < 20 && bus_idle !== 1'b1; n++)
			@(negedge core_clk);
	endtask
	task automatic wr(input logic [7:0] d, input logic x);
		push(2'h1, d, 1'b0);
		ev();
		chk("wbyte", m_rx, d);
		chk("ack", {6'h0, ack_seen, nack_seen}, x ? 8'h01 : 8'h02);
	endtask
	task automatic rd(input logic [7:0] d, input logic l);
		tx_byte = d;
		push(2'h2, 8'h00, l);
		ev();
		chk("rbyte", rd_data, d);
		chk("mack", {7'h0, mack}, {7'h0, l});
	endtask
	task automatic t_pwr;
		int n;
		chk("rstq", {5'h0, sda_oe, scl_oe, busy}, 8'h01);
		rst = 1'b0;
		for (n = 0; n < 100 && busy !== 1'b0; n++)
			@(negedge core_clk);
		if (n == 100)
			tmo();
		chk("pwrup", {7'h0, n >= 20}, 8'h01);
		chk("idle", {7'h0, bus_idle}, 8'h01);
	endtask
	task automatic t_wr;
		push(2'h0, 8'h00, 1'b0);
		wr(8'ha5, 1'b0);
		wr(8'h3c, 1'b0);
		nak = 1'b1;
		wr(8'h0f, 1'b1);
		nak = 1'b0;
		push(2'h3, 8'h00, 1'b0);
		idle();
		chk("stop", {7'h0, bus_idle}, 8'h01);
	endtask
	// both read bytes share bit 7, as the next byte may already be on the wire
	task automatic t_rd;
		tx = 1'b1;
		push(2'h0, 8'h00, 1'b0);
		rd(8'h96, 1'b0);
		rd(8'ha9, 1'b1);
		tx = 1'b0;
		push(2'h0, 8'h00, 1'b0);
		wr(8'hc3, 1'b0);
		push(2'h3, 8'h00, 1'b0);
		idle();
	endtask
	task automatic t_fifo;
		int k;
		int i;
		push(2'h0, 8'h00, 1'b0);
		@(negedge core_clk);
		cmd = 2'h1;
		cmd_data = 8'h10;
		cmd_valid = 1'b1;
		k = 0;
		while (k < 12 && cmd_ready)
		begin
			@(negedge core_clk);
			k++;
			cmd_data = 8'h10 + 8'(k);
		end
		cmd_valid = 1'b0;
		chk("full", {6'h0, cmd_ready, k >= 8}, 8'h01);
		push(2'h3, 8'h00, 1'b0);
		for (i = 0; i < k; i++)
		begin
			ev();
			chk("fbyte", m_rx, 8'h10 + 8'(i));
		end
		idle();
	endtask
	task automatic t_rec;
		int s;
		int n;
		jam = 1'b1;
		@(negedge core_clk);
		recover = 1'b1;
		s = rises;
		for (n = 0; n < 20 && !busy; n++)
			@(negedge core_clk);
		recover = 1'b0;
		jam = 1'b0;
		idle();
		chk("recn", {7'h0, (rises - s) inside {[5:10]}}, 8'h01);
		chk("recidle", {7'h0, bus_idle}, 8'h01);
	endtask
	initial
	begin
		rst = 1'b1;
		repeat (8) @(negedge core_clk);
		t_pwr();
		t_wr();
		t_rd();
		t_fifo();
		t_rec();
		summarize();
	end
endmodule // tb_top
bind tws_master tws_chk_sva #(.PWRUP_CYC(PWRUP_CYC)) chk_i (.core_clk, .rst, .busy,
	.bus_idle, .ack_seen, .nack_seen, .rd_valid, .scl_o, .scl_oe, .sda_oe, .scl_i, .sda_i);
